// ===== hdl/sfbi_pkg.sv
// Constants for the status-flag and bit instruction unit.
// Assumes the core supplies pre-decoded opcodes on the unit's ports.
package sfbi_pkg;
	// ----------------------------------------------------------------
	// Status register bit positions
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] REG_RESET    = 8'h00;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam int unsigned SINGLE_CYCLES = 1;
	localparam int unsigned SLEEP_CYCLES  = 3;
	localparam logic [1:0]  SLEEP_LAST    = 2'(SLEEP_CYCLES - 1);

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SFBI_OP_NOP,
		SFBI_OP_BIT_STORE,
		SFBI_OP_BIT_LOAD,
		SFBI_OP_FLAG_SET,
		SFBI_OP_FLAG_CLEAR,
		SFBI_OP_SLEEP,
		SFBI_OP_WDOG_RESTART
	} sfbi_op_t;

	typedef enum logic {
		SFBI_IDLE,
		SFBI_SLEEPING
	} sfbi_state_t;
endpackage

// ===== hdl/sfbi_unit.sv
// Executes bit transfer, flag set/clear, no-op, sleep and watchdog restart.
// Assumes the core holds opValid for one cycle per instruction when busy is low.
// What this block does
// - Bit store copies chosen source bit into T; one cycle, no other flag.
// - Bit load writes T into chosen destination bit; one cycle, flags unchanged.
// - Overflow set/clear force V to one/zero in one cycle only.
// - Half carry set/clear force H to one/zero in one cycle only.
// - Signed test set/clear force S to one/zero in one cycle only.
// - Sleep changes no flag, takes three cycles, then requests sleep mode.
// - Watchdog restart takes one cycle, no flag change, pulses watchdog restart.
`timescale 1ns/1ps
`default_nettype none
module sfbi_unit (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             clkEn,
	input  wire logic             opValid,
	input  wire sfbi_pkg::sfbi_op_t opCode,
	input  wire logic [2:0]       bitSel,
	input  wire logic [7:0]       srcReg,
	input  wire logic [7:0]       dstReg,
	output logic [7:0]            statusReg,
	output logic [7:0]            regOut,
	output logic                  regWrite,
	output logic                  done,
	output logic                  busy,
	output logic                  sleepReq,
	output logic                  wdogRestart
);
	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	sfbi_pkg::sfbi_state_t state;
	logic [1:0]            sleepCnt;
	wire logic             take      = opValid && (state == sfbi_pkg::SFBI_IDLE);
	wire logic             isStore   = take && (opCode == sfbi_pkg::SFBI_OP_BIT_STORE);
	wire logic             isLoad    = take && (opCode == sfbi_pkg::SFBI_OP_BIT_LOAD);
	wire logic             isSet     = take && (opCode == sfbi_pkg::SFBI_OP_FLAG_SET);
	wire logic             isClr     = take && (opCode == sfbi_pkg::SFBI_OP_FLAG_CLEAR);
	wire logic             isSleep   = take && (opCode == sfbi_pkg::SFBI_OP_SLEEP);
	wire logic             isWdog    = take && (opCode == sfbi_pkg::SFBI_OP_WDOG_RESTART);
	wire logic             single    = take && !isSleep;
	wire logic [7:0]       bitMask   = 8'h01 << bitSel;
	wire logic             sleepEnd  = (state == sfbi_pkg::SFBI_SLEEPING)
		&& (sleepCnt == sfbi_pkg::SLEEP_LAST);

	// A flag op names its bit with bitSel, so one encoding covers every flag,
	// including V, H and S; only the named bit may move.
	wire logic [7:0] next_status =
		isStore ? ((statusReg & ~(8'h01 << sfbi_pkg::FLAG_T))
			| ({7'h00, srcReg[bitSel]} << sfbi_pkg::FLAG_T)) :
		isSet ? (statusReg | bitMask) :
		isClr ? (statusReg & ~bitMask) :
		statusReg;
	wire logic [7:0] next_regOut = (dstReg & ~bitMask)
		| (statusReg[sfbi_pkg::FLAG_T] ? bitMask : 8'h00);

	// ----------------------------------------------------------------
	// Status and result registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			statusReg   <= sfbi_pkg::STATUS_RESET;
			regOut      <= sfbi_pkg::REG_RESET;
			regWrite    <= 1'b0;
			done        <= 1'b0;
			wdogRestart <= 1'b0;
		end else if (clkEn) begin
			statusReg   <= next_status;
			regOut      <= isLoad ? next_regOut : regOut;
			regWrite    <= isLoad;
			done        <= single || sleepEnd;
			wdogRestart <= isWdog;
		end
	end

	// ----------------------------------------------------------------
	// Sleep sequencer
	// ----------------------------------------------------------------
	// The request is raised as the third cycle retires so the sleep
	// controller sees it exactly once per instruction.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state    <= sfbi_pkg::SFBI_IDLE;
			sleepCnt <= 2'h0;
			busy     <= 1'b0;
			sleepReq <= 1'b0;
		end else if (clkEn) begin
			sleepReq <= sleepEnd;
			case (state)
				sfbi_pkg::SFBI_IDLE: begin
					sleepCnt <= 2'h1;
					busy     <= isSleep;
					if (isSleep) begin
						state <= sfbi_pkg::SFBI_SLEEPING;
					end
				end
				sfbi_pkg::SFBI_SLEEPING: begin
					sleepCnt <= sleepCnt + 2'h1;
					if (sleepEnd) begin
						state <= sfbi_pkg::SFBI_IDLE;
						busy  <= 1'b0;
					end
				end
				default: begin
					state <= sfbi_pkg::SFBI_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== tb/sfbi_monitor.sv
// Checker for the status-flag and bit unit, bound into every sfbi_unit.
// Assumes registered outputs that answer one cycle after each take.
`timescale 1ns/1ps
`default_nettype none
module sfbi_monitor (
	input wire logic               clk_sys, nrst, clkEn, opValid,
	input wire sfbi_pkg::sfbi_op_t opCode,
	input wire logic [2:0]         bitSel,
	input wire logic [7:0]         srcReg, dstReg, statusReg, regOut,
	input wire logic               regWrite, done, busy, sleepReq, wdogRestart
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire tk = clkEn && opValid && !busy;
	wire st = tk && opCode == sfbi_pkg::SFBI_OP_BIT_STORE;
	wire ld = tk && opCode == sfbi_pkg::SFBI_OP_BIT_LOAD;
	wire fs = tk && opCode == sfbi_pkg::SFBI_OP_FLAG_SET;
	wire fc = tk && opCode == sfbi_pkg::SFBI_OP_FLAG_CLEAR;
	wire sl = tk && opCode == sfbi_pkg::SFBI_OP_SLEEP;
	wire wd = tk && opCode == sfbi_pkg::SFBI_OP_WDOG_RESTART;
	a_store_copies_t:
	assert property (st |=> done && statusReg[6] == $past(srcReg[bitSel])
		&& {statusReg[7], statusReg[5:0]} == $past({statusReg[7], statusReg[5:0]}))
		else $error("bit store wrong");
	a_load_writes_bit:
	assert property (ld |=> regWrite && done && statusReg == $past(statusReg)
		&& regOut[$past(bitSel)] == $past(statusReg[6])) else $error("bit load wrong");
	a_set_one_flag:
	assert property (fs |=> done && !regWrite
		&& statusReg == ($past(statusReg) | 8'h01 << $past(bitSel))) else $error("flag set wrong");
	a_clear_one_flag:
	assert property (fc |=> done && !regWrite
		&& statusReg == ($past(statusReg) & ~(8'h01 << $past(bitSel)))) else $error("clear wrong");
	a_sleep_three_cycles:
	assert property (sl |=> busy [*2] ##1 (done && sleepReq && !busy
		&& statusReg == $past(statusReg, 3))) else $error("sleep timing wrong");
	a_sleep_req_cause:
	assert property ($rose(sleepReq) |-> $past(sl, 3)) else $error("stray sleep request");
	a_wdog_one_cycle:
	assert property (wd |=> wdogRestart && done && $stable(statusReg)) else $error("wdog wrong");
	a_wdog_cause:
	assert property (wdogRestart |-> $past(wd)) else $error("stray watchdog restart");
	cover property (sl);
	cover property (fc);
	cover property (ld);
endmodule
bind sfbi_unit sfbi_monitor mon (.*);
`default_nettype wire

// ===== tb/test_sfbi_unit.sv
// Self-checking bench for the status-flag and bit unit.
// Assumes outputs have settled at the falling edge after each take.
`timescale 1ns/1ps
`default_nettype none
module test_sfbi_unit;
	logic               clk_sys = 1'h0, nrst = 1'h0, clkEn = 1'h1, opValid = 1'h0;
	sfbi_pkg::sfbi_op_t opCode = sfbi_pkg::SFBI_OP_NOP;
	logic [2:0]         bitSel = 3'h0;
	logic [7:0]         srcReg = 8'h00, dstReg = 8'h00, statusReg, regOut, s = 8'h00;
	logic               regWrite, done, busy, sleepReq, wdogRestart;
	int                 num_errors = 0, num_checks = 0;
	always #50 clk_sys = ~clk_sys;
	sfbi_unit uut (.*);
	// Inputs held over one rising edge so each call is at most one take.
	task op(sfbi_pkg::sfbi_op_t c, logic [2:0] b, logic [7:0] r);
		opValid = 1'h1;
		opCode = c;
		bitSel = b;
		srcReg = r;
		dstReg = r;
		@(negedge clk_sys);
	endtask
	task chk(logic [7:0] g, logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task conclude();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		nrst = 1'h1;
		for (int i = 0; i < 16; i++) begin
			op(i < 8 ? sfbi_pkg::SFBI_OP_FLAG_SET : sfbi_pkg::SFBI_OP_FLAG_CLEAR, 3'(i), 8'h00);
			s[i[2:0]] = ~i[3];
			chk(statusReg, s);
		end
		op(sfbi_pkg::SFBI_OP_FLAG_SET, 3'h3, 8'h00);
		op(sfbi_pkg::SFBI_OP_BIT_STORE, 3'h5, 8'h20);
		s = 8'h48;
		chk(statusReg, s);
		op(sfbi_pkg::SFBI_OP_BIT_LOAD, 3'h1, 8'hf0);
		chk(regOut, 8'hf2);
		chk(8'(regWrite), 8'h01);
		chk(8'(done), 8'h01);
		chk(statusReg, s);
		op(sfbi_pkg::SFBI_OP_WDOG_RESTART, 3'h0, 8'h00);
		chk(8'(wdogRestart), 8'h01);
		chk(8'(regWrite), 8'h00);
		chk(statusReg, s);
		// A set sent while sleeping must be dropped, so status stays put.
		op(sfbi_pkg::SFBI_OP_SLEEP, 3'h0, 8'h00);
		op(sfbi_pkg::SFBI_OP_FLAG_SET, 3'h0, 8'h00);
		chk(8'(busy), 8'h01);
		opValid = 1'h0;
		@(negedge clk_sys);
		chk(8'(sleepReq), 8'h01);
		chk(8'(done), 8'h01);
		chk(8'(busy), 8'h00);
		chk(statusReg, s);
		// With the clock enable low a set must not land.
		clkEn = 1'h0;
		op(sfbi_pkg::SFBI_OP_FLAG_SET, 3'h0, 8'h00);
		chk(statusReg, s);
		opValid = 1'h0;
		clkEn = 1'h1;
		@(negedge clk_sys);
		chk(statusReg, s);
		chk(8'(done), 8'h00);
		conclude();
	end
	initial begin
		repeat (1000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end
endmodule
`default_nettype wire
